// ==== rtl/kec_top.sv ====
// kec_top: per-lane error-code substitution on tx and rx columns, lane 0
// end-of-packet error counting, and the AXI4-Lite register slave.
// assumes one 250 MHz clock, synchronous active-high reset, and that the
// datapath flags per-lane error conditions alongside each column.
//
// Summary of operation
// - KR mode: erroring lane sends its code
// - code msb is control flag, low eight data
// - lane 1 code resets to 8'h00, flag 0
// - lane 2 code resets to 8'h00, flag 0
// - lane 3 code resets to 8'h01, flag 0
// - code register bits 6:0 read zero
// - lane 0 terminate needs /K/ in lanes 1-3
// - lane 0 terminate needs K or A next
// - 16-bit error count clears on read
// - lane 0 code resets to 8'h9C, flag 1
`timescale 1ns/1ps
module kec_top (
  // clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_srst,
  // axi4-lite write address and data
  input  wire logic                      i_s_axi_awvalid,
  output logic                           o_s_axi_awready,
  input  wire logic [kec_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                      i_s_axi_wvalid,
  output logic                           o_s_axi_wready,
  input  wire logic [31:0]               i_s_axi_wdata,
  input  wire logic [3:0]                i_s_axi_wstrb,
  // axi4-lite write response
  output logic                           o_s_axi_bvalid,
  input  wire logic                      i_s_axi_bready,
  output logic [1:0]                     o_s_axi_bresp,
  // axi4-lite read
  input  wire logic                      i_s_axi_arvalid,
  output logic                           o_s_axi_arready,
  input  wire logic [kec_pkg::ADDR_W-1:0] i_s_axi_araddr,
  output logic                           o_s_axi_rvalid,
  input  wire logic                      i_s_axi_rready,
  output logic [31:0]                    o_s_axi_rdata,
  output logic [1:0]                     o_s_axi_rresp,
  // transmit column in
  input  wire logic                      i_tx_valid,
  output logic                           o_tx_ready,
  input  wire kec_pkg::kec_ecol_t        i_tx_col,
  // transmit column out
  output logic                           o_tx_valid,
  input  wire logic                      i_tx_out_ready,
  output kec_pkg::kec_col_t              o_tx_col,
  // receive column in
  input  wire logic                      i_rx_valid,
  output logic                           o_rx_ready,
  input  wire kec_pkg::kec_ecol_t        i_rx_col,
  // receive column out, through the fifo
  output logic                           o_rx_valid,
  input  wire logic                      i_rx_out_ready,
  output kec_pkg::kec_col_t              o_rx_col
);

  typedef struct packed {
    logic [3:0][8:0]   code;
    logic              kr_mode;
    logic [15:0]       eop0_cnt;
    logic [15:0]       eop1_cnt;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic              tx_valid;
    kec_pkg::kec_col_t tx_col;
  } kec_top_state_t;

  kec_top_state_t       st_reg;
  kec_top_state_t       st_next;
  kec_top_state_t       st_rst;
  kec_pkg::kec_col_t    tx_sub;
  kec_pkg::kec_col_t    rx_sub;
  logic                 wr_take;
  logic                 rd_take;
  logic [15:0]          wr_idx;
  logic [15:0]          rd_idx;
  logic                 tx_take;
  logic                 rx_take;
  logic                 eop_err;
  logic                 fifo_in_ready;

  // register indices from word addresses
  assign wr_idx = i_s_axi_awaddr[kec_pkg::ADDR_W-1:2];
  assign rd_idx = i_s_axi_araddr[kec_pkg::ADDR_W-1:2];

  // write taken only with address and data together, one at a time
  assign wr_take         = i_s_axi_awvalid && i_s_axi_wvalid && !st_reg.bvalid;
  assign o_s_axi_awready = wr_take;
  assign o_s_axi_wready  = wr_take;
  assign rd_take         = i_s_axi_arvalid && !st_reg.rvalid;
  assign o_s_axi_arready = !st_reg.rvalid;

  // per-lane code substitution on both paths
  for (genvar i = 0; i < 4; i++) begin : g_sub
    // flag to ctrl, low eight to data
    assign tx_sub.ctrl[i]       = (st_reg.kr_mode && i_tx_col.err[i]) ?
                                  st_reg.code[i][kec_pkg::CODE_CTL_BIT] : i_tx_col.col.ctrl[i];
    assign tx_sub.data[8*i +: 8] = (st_reg.kr_mode && i_tx_col.err[i]) ?
                                  st_reg.code[i][7:0] : i_tx_col.col.data[8*i +: 8];
    assign rx_sub.ctrl[i]       = (st_reg.kr_mode && i_rx_col.err[i]) ?
                                  st_reg.code[i][kec_pkg::CODE_CTL_BIT] : i_rx_col.col.ctrl[i];
    assign rx_sub.data[8*i +: 8] = (st_reg.kr_mode && i_rx_col.err[i]) ?
                                  st_reg.code[i][7:0] : i_rx_col.col.data[8*i +: 8];
  end

  // tx output stage stalls the source when the sink does
  assign o_tx_ready = !st_reg.tx_valid || i_tx_out_ready;
  assign tx_take    = i_tx_valid && o_tx_ready;
  assign o_tx_valid = st_reg.tx_valid;
  assign o_tx_col   = st_reg.tx_col;

  // rx path goes through the fifo; its ready is the source's ready
  assign o_rx_ready = fifo_in_ready;
  assign rx_take    = i_rx_valid && fifo_in_ready;

  kec_fifo #(
    .WIDTH ($bits(kec_pkg::kec_col_t)),
    .DEPTH (kec_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clock     (i_clock),
    .i_srst      (i_srst),
    .i_in_valid  (i_rx_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (rx_sub),
    .o_out_valid (o_rx_valid),
    .i_out_ready (i_rx_out_ready),
    .o_out_data  (o_rx_col)
  );

  // lane 0 terminate check on received columns as they arrive
  kec_eop_check u_eop (
    .i_clock     (i_clock),
    .i_srst      (i_srst),
    .i_col_valid (rx_take),
    .i_col       (i_rx_col.col),
    .o_eop_err   (eop_err)
  );

  // values after reset
  always_comb begin
    st_rst          = '0;
    st_rst.code[0]  = kec_pkg::CODE_LN0_RST[kec_pkg::CODE_MSB:kec_pkg::CODE_LSB];
    st_rst.code[1]  = kec_pkg::CODE_LN1_RST[kec_pkg::CODE_MSB:kec_pkg::CODE_LSB];
    st_rst.code[2]  = kec_pkg::CODE_LN2_RST[kec_pkg::CODE_MSB:kec_pkg::CODE_LSB];
    st_rst.code[3]  = kec_pkg::CODE_LN3_RST[kec_pkg::CODE_MSB:kec_pkg::CODE_LSB];
    st_rst.kr_mode  = kec_pkg::CONTROL_RST[kec_pkg::CTRL_KR_BIT];
    st_rst.eop0_cnt = kec_pkg::EOP_CNT_RST;
    st_rst.eop1_cnt = kec_pkg::EOP_CNT_RST;
  end

  // next state: bus slave, counters, tx stage
  always_comb begin
    st_next = st_reg;

    // tx stage
    if (tx_take) begin
      st_next.tx_valid = 1'b1;
      st_next.tx_col   = tx_sub;
    end else if (i_tx_out_ready) begin
      st_next.tx_valid = 1'b0;
    end

    // write response retires
    if (st_reg.bvalid && i_s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // write decode with byte strobes
    if (wr_take) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = kec_pkg::RESP_OKAY;
      case (wr_idx)
        kec_pkg::IDX_CODE_LN0,
        kec_pkg::IDX_CODE_LN1,
        kec_pkg::IDX_CODE_LN2,
        kec_pkg::IDX_CODE_LN3: begin
          if (i_s_axi_wstrb[1]) begin
            st_next.code[2'(wr_idx - kec_pkg::IDX_CODE_LN0)][8:1] = i_s_axi_wdata[15:8];
          end
          if (i_s_axi_wstrb[0]) begin
            st_next.code[2'(wr_idx - kec_pkg::IDX_CODE_LN0)][0] = i_s_axi_wdata[7];
          end
        end
        kec_pkg::IDX_CONTROL: begin
          if (i_s_axi_wstrb[0]) begin
            st_next.kr_mode = i_s_axi_wdata[kec_pkg::CTRL_KR_BIT];
          end
        end
        kec_pkg::IDX_EOP_LN0,
        kec_pkg::IDX_EOP_LN1: begin
          st_next.bresp = kec_pkg::RESP_OKAY; // counters ignore writes
        end
        default: begin
          st_next.bresp = kec_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read response retires
    if (st_reg.rvalid && i_s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // read decode
    if (rd_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = kec_pkg::RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      case (rd_idx)
        kec_pkg::IDX_CODE_LN0,
        kec_pkg::IDX_CODE_LN1,
        kec_pkg::IDX_CODE_LN2,
        kec_pkg::IDX_CODE_LN3: begin
          st_next.rdata[kec_pkg::CODE_MSB:kec_pkg::CODE_LSB] =
            st_reg.code[2'(rd_idx - kec_pkg::IDX_CODE_LN0)];
        end
        kec_pkg::IDX_EOP_LN0: begin
          st_next.rdata[15:0] = st_reg.eop0_cnt;
        end
        kec_pkg::IDX_EOP_LN1: begin
          st_next.rdata[15:0] = st_reg.eop1_cnt;
          st_next.eop1_cnt    = 16'h0000;
        end
        kec_pkg::IDX_CONTROL: begin
          st_next.rdata[kec_pkg::CTRL_KR_BIT] = st_reg.kr_mode;
        end
        default: begin
          st_next.rresp = kec_pkg::RESP_SLVERR;
        end
      endcase
    end

    // clear on read, new error wins
    // count up, hold at all ones
    if (rd_take && (rd_idx == kec_pkg::IDX_EOP_LN0)) begin
      st_next.eop0_cnt = eop_err ? 16'h0001 : 16'h0000;
    end else if (eop_err && (st_reg.eop0_cnt != kec_pkg::EOP_CNT_MAX)) begin
      st_next.eop0_cnt = st_reg.eop0_cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_reg <= st_rst;
    end else begin
      st_reg <= st_next;
    end
  end

  // bus outputs straight from state
  assign o_s_axi_bvalid = st_reg.bvalid;
  assign o_s_axi_bresp  = st_reg.bresp;
  assign o_s_axi_rvalid = st_reg.rvalid;
  assign o_s_axi_rresp  = st_reg.rresp;
  assign o_s_axi_rdata  = st_reg.rdata;

endmodule : kec_top

// ==== rtl/kec_pkg.sv ====
// kec_pkg: register indices, reset values, characters and carrier types
// for the lane error-code and lane 0 end-of-packet check block.
// assumes one core clock; registers reached over AXI4-Lite, 32-bit data.
package kec_pkg;

  // bus geometry: byte address = 4 * register index
  localparam int          ADDR_W       = 18;
  localparam int          IDX_W        = 16;
  localparam int          FIFO_DEPTH   = 8;

  // register indices
  localparam logic [15:0] IDX_CODE_LN0 = 16'h8005;
  localparam logic [15:0] IDX_CODE_LN1 = 16'h8006;
  localparam logic [15:0] IDX_CODE_LN2 = 16'h8007;
  localparam logic [15:0] IDX_CODE_LN3 = 16'h8008;
  localparam logic [15:0] IDX_EOP_LN0  = 16'h8010;
  localparam logic [15:0] IDX_EOP_LN1  = 16'h8011;
  localparam logic [15:0] IDX_CONTROL  = 16'h8020;

  // values after reset
  localparam logic [15:0] CODE_LN0_RST = 16'hCE00;
  localparam logic [15:0] CODE_LN1_RST = 16'h0000;
  localparam logic [15:0] CODE_LN2_RST = 16'h0000;
  localparam logic [15:0] CODE_LN3_RST = 16'h0080;
  localparam logic [15:0] EOP_CNT_RST  = 16'hFFFD;
  localparam logic [15:0] EOP_CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CONTROL_RST  = 16'h0001;

  // field positions
  localparam int          CODE_MSB     = 15;
  localparam int          CODE_LSB     = 7;
  localparam int          CODE_CTL_BIT = 8;
  localparam int          CTRL_KR_BIT  = 0;

  // xgmii control characters
  localparam logic [7:0]  CHAR_TERM    = 8'hFD;
  localparam logic [7:0]  CHAR_K       = 8'hBC;
  localparam logic [7:0]  CHAR_A       = 8'h7C;

  // axi responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // one xgmii column: four lanes, lane 0 in the low byte
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [31:0] data;
  } kec_col_t;

  // column with per-lane error conditions from the datapath
  typedef struct packed {
    logic [3:0] err;
    kec_col_t   col;
  } kec_ecol_t;

endpackage : kec_pkg

// ==== rtl/kec_fifo.sv ====
// kec_fifo: synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module kec_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } kec_fifo_state_t;

  kec_fifo_state_t st_reg;
  kec_fifo_state_t st_next;
  logic            push;
  logic            pop;

  // honest full and empty from the fill count
  assign o_in_ready  = (st_reg.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st_reg.count != '0);
  assign o_out_data  = st_reg.mem[st_reg.rptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wptr] = i_in_data;
      st_next.wptr             = (st_reg.wptr == AW'(DEPTH-1)) ? '0 : st_reg.wptr + 1'b1;
    end
    if (pop) begin
      st_next.rptr = (st_reg.rptr == AW'(DEPTH-1)) ? '0 : st_reg.rptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : kec_fifo

// ==== rtl/kec_eop_check.sv ====
// kec_eop_check: watches accepted columns for a malformed lane 0 terminate.
// assumes columns arrive in order, one per i_col_valid cycle.
`timescale 1ns/1ps
module kec_eop_check (
  // clock and reset
  input  wire logic            i_clock,
  input  wire logic            i_srst,
  // watched column
  input  wire logic            i_col_valid,
  input  wire kec_pkg::kec_col_t i_col,
  // one-cycle error pulse
  output logic                 o_eop_err
);

  typedef struct packed {
    logic pending;
    logic lanes_bad;
    logic err;
  } kec_eop_state_t;

  kec_eop_state_t st_reg;
  kec_eop_state_t st_next;
  logic [3:0]     is_k;
  logic [3:0]     is_a;
  logic           term0;

  // per-lane character match
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign is_k[i] = i_col.ctrl[i] && (i_col.data[8*i +: 8] == kec_pkg::CHAR_K);
    assign is_a[i] = i_col.ctrl[i] && (i_col.data[8*i +: 8] == kec_pkg::CHAR_A);
  end
  assign term0 = i_col.ctrl[0] && (i_col.data[7:0] == kec_pkg::CHAR_TERM);

  // terminate tracking, one error per terminate column
  always_comb begin
    st_next     = st_reg;
    st_next.err = 1'b0;
    if (i_col_valid) begin
      if (st_reg.pending) begin
        // bad lanes 1-3 on the terminate, or next column not all K or all A
        st_next.err = st_reg.lanes_bad || !((&is_k) || (&is_a));
      end
      st_next.pending   = term0;
      st_next.lanes_bad = term0 && !(&is_k[3:1]);
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_eop_err = st_reg.err;

endmodule : kec_eop_check

// ==== bench/kec_top_assertions.sv ====
// kec_top_assertions: handshake, hold and datapath checks on kec_top ports.
// assumes it is bound to every kec_top instance.
`timescale 1ns/1ps
module kec_checker (
  // clock and reset
  input wire logic                       i_clock,
  input wire logic                       i_srst,
  // register bus
  input wire logic                       i_s_axi_awvalid,
  input wire logic                       o_s_axi_awready,
  input wire logic                       o_s_axi_bvalid,
  input wire logic                       i_s_axi_bready,
  input wire logic [1:0]                 o_s_axi_bresp,
  input wire logic                       i_s_axi_arvalid,
  input wire logic                       o_s_axi_arready,
  input wire logic [kec_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic                       o_s_axi_rvalid,
  input wire logic                       i_s_axi_rready,
  input wire logic [31:0]                o_s_axi_rdata,
  // columns
  input wire logic                       i_tx_valid,
  input wire logic                       o_tx_ready,
  input wire kec_pkg::kec_ecol_t         i_tx_col,
  input wire logic                       o_tx_valid,
  input wire logic                       i_tx_out_ready,
  input wire kec_pkg::kec_col_t          o_tx_col,
  input wire logic                       o_rx_valid,
  input wire logic                       i_rx_out_ready,
  input wire kec_pkg::kec_col_t          o_rx_col
);
  logic code_rd_reg;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // marks a read in flight that targets a code register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      code_rd_reg <= 1'b0;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      code_rd_reg <= i_s_axi_araddr[17:2] inside {[16'h8005:16'h8008]};
    end
  end
  a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready |=> o_s_axi_bvalid)
    else $error("write taken without a response next cycle");
  a_bresp_hold: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped before bready");
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read taken without an answer next cycle");
  a_rdata_hold: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped before rready");
  a_code_low_zero: assert property (
    o_s_axi_rvalid && code_rd_reg |-> o_s_axi_rdata[6:0] == 7'h00)
    else $error("code register low bits not zero");
  a_tx_answer: assert property (i_tx_valid && o_tx_ready |=> o_tx_valid)
    else $error("tx column not presented next cycle");
  a_tx_pass: assert property (
    i_tx_valid && o_tx_ready && i_tx_col.err == 4'h0 |=> o_tx_col == $past(i_tx_col.col))
    else $error("error-free tx column altered");
  a_tx_hold: assert property (o_tx_valid && !i_tx_out_ready |=> o_tx_valid && $stable(o_tx_col))
    else $error("tx column changed while stalled");
  a_rx_hold: assert property (o_rx_valid && !i_rx_out_ready |=> o_rx_valid && $stable(o_rx_col))
    else $error("rx column changed while stalled");
  c_bresp_wait: cover property (o_s_axi_bvalid && !i_s_axi_bready);
  c_tx_subst: cover property (i_tx_valid && o_tx_ready && i_tx_col.err != 4'h0);
  c_rx_stall: cover property (o_rx_valid && !i_rx_out_ready);
endmodule : kec_checker

bind kec_top kec_checker u_chk (
  .i_clock(i_clock), .i_srst(i_srst), .i_s_axi_awvalid(i_s_axi_awvalid),
  .o_s_axi_awready(o_s_axi_awready), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .o_s_axi_bresp(o_s_axi_bresp),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .i_s_axi_araddr(i_s_axi_araddr), .o_s_axi_rvalid(o_s_axi_rvalid),
  .i_s_axi_rready(i_s_axi_rready), .o_s_axi_rdata(o_s_axi_rdata), .i_tx_valid(i_tx_valid),
  .o_tx_ready(o_tx_ready), .i_tx_col(i_tx_col), .o_tx_valid(o_tx_valid),
  .i_tx_out_ready(i_tx_out_ready), .o_tx_col(o_tx_col), .o_rx_valid(o_rx_valid),
  .i_rx_out_ready(i_rx_out_ready), .o_rx_col(o_rx_col)
);

// ==== bench/kec_xgmii_sink.sv ====
// kec_xgmii_sink: far-side column sink that can stall or take every other cycle.
// assumes the bench sets the pacing inputs at clock edges.
`timescale 1ns/1ps
module kec_xgmii_sink (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_srst,
  // pacing controls
  input  wire logic i_stall,
  input  wire logic i_slow,
  // column handshake
  output logic      o_ready
);
  logic phase_reg;
  // pacing phase
  always_ff @(posedge i_clock) begin
    phase_reg <= i_srst ? 1'b0 : !phase_reg;
  end
  assign o_ready = !i_stall && (!i_slow || phase_reg);
endmodule : kec_xgmii_sink

// ==== bench/kec_top_tb.sv ====
// kec_top_tb: register, substitution, fifo and end-of-packet scenarios.
// assumes kec_top with the checker bound and two column sinks.
`timescale 1ns/1ps
module kec_top_tb;
  localparam logic [39:0] T_BAD = {4'h0, 4'h1, 32'h000000FD};
  localparam logic [39:0] T_OK  = {4'h0, 4'hF, 32'hBCBCBCFD};
  localparam logic [39:0] K_COL = {4'h0, 4'hF, 32'hBCBCBCBC};
  localparam logic [39:0] A_COL = {4'h0, 4'hF, 32'h7C7C7C7C};
  localparam logic [39:0] D_COL = {4'h0, 4'h0, 32'h00000000};
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, txv = 0, rxv = 0;
  logic tx_sl = 0, rx_st = 0, rx_sl = 0;
  logic [17:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  kec_pkg::kec_ecol_t txc = '0, rxc = '0;
  logic awr, wrd, bv, arr, rv, txr, txov, rxr, rxov, txrdy, rxrdy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  kec_pkg::kec_col_t txo, rxo;
  int bad_count = 0, n_compared = 0;
  kec_top uut (
    .i_clock(clk), .i_srst(rst), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rry), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .i_tx_valid(txv),
    .o_tx_ready(txr), .i_tx_col(txc), .o_tx_valid(txov), .i_tx_out_ready(txrdy),
    .o_tx_col(txo), .i_rx_valid(rxv), .o_rx_ready(rxr), .i_rx_col(rxc),
    .o_rx_valid(rxov), .i_rx_out_ready(rxrdy), .o_rx_col(rxo));
  kec_xgmii_sink u_txs (.i_clock(clk), .i_srst(rst), .i_stall(1'b0), .i_slow(tx_sl),
    .o_ready(txrdy));
  kec_xgmii_sink u_rxs (.i_clock(clk), .i_srst(rst), .i_stall(rx_st), .i_slow(rx_sl),
    .o_ready(rxrdy));
  // clock
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic lim(input int i);
    if (i >= 64) begin
      bad_count++;
      print_verdict();
    end
  endtask : lim
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    int i;
    awv <= 1;
    wv <= 1;
    awa <= {idx, 2'b00};
    wd <= d;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (awr) wv <= 0;
      if (bv && bry) break;
      if (bv) bry <= 1;
    end
    lim(i);
    bry <= 0;
    chk({34'h0, bresp}, {34'h0, er});
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
    int i;
    arv <= 1;
    ara <= {idx, 2'b00};
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv && rry) break;
      if (rv) rry <= 1;
    end
    lim(i);
    rry <= 0;
    chk({2'h0, rresp, rdat}, {2'h0, er, e});
  endtask : rd
  task automatic tx(input kec_pkg::kec_ecol_t c, input kec_pkg::kec_col_t e);
    int i;
    txv <= 1;
    txc <= c;
    for (i = 0; i < 64 && !txr; i++) @(posedge clk);
    @(posedge clk);
    txv <= 0;
    for (i = 0; i < 64 && !(txov && txrdy); i++) @(posedge clk);
    lim(i);
    chk(txo, e);
    @(posedge clk);
  endtask : tx
  task automatic push(input kec_pkg::kec_ecol_t c);
    int i;
    rxv <= 1;
    rxc <= c;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (rxr) break;
    end
    lim(i);
  endtask : push
  task automatic term(input logic [39:0] a, input logic [39:0] b);
    push(a);
    push(b);
    rxv <= 0;
    repeat (4) @(posedge clk);
  endtask : term
  task automatic t_reset_values();
    rd(16'h8005, 32'h0000CE00, 2'h0);
    rd(16'h8006, 32'h00000000, 2'h0);
    rd(16'h8007, 32'h00000000, 2'h0);
    rd(16'h8008, 32'h00000080, 2'h0);
    rd(16'h8011, 32'h0000FFFD, 2'h0);
    rd(16'h8011, 32'h00000000, 2'h0);
  endtask : t_reset_values
  task automatic t_codes();
    wr(16'h8006, 32'h0000D280, 2'h0);
    rd(16'h8006, 32'h0000D280, 2'h0);
    wr(16'h8008, 32'hFFFFFFFF, 2'h0);
    rd(16'h8008, 32'h0000FF80, 2'h0);
    tx_sl <= 1;
    tx({4'h3, 4'h0, 32'h44332211}, {4'h3, 32'h4433A59C});
    tx({4'h8, 4'h0, 32'h44332211}, {4'h8, 32'hFF332211});
    tx({4'h0, 4'h5, 32'h01020304}, {4'h5, 32'h01020304});
    wr(16'h8020, 32'h00000000, 2'h0);
    tx({4'hF, 4'h0, 32'h44332211}, {4'h0, 32'h44332211});
    wr(16'h8020, 32'h00000001, 2'h0);
    wr(16'h8030, 32'h00000001, 2'h2);
    rd(16'h8030, 32'h00000000, 2'h2);
  endtask : t_codes
  task automatic t_fifo();
    int k;
    int i;
    rx_st <= 1;
    for (k = 0; k < 8; k++) push({k[0], 3'h0, 4'h0, 8'h10, 24'h203040 + k[7:0]});
    rxv <= 0;
    #1;
    chk(rxr, 1'b0);
    @(posedge clk);
    rx_st <= 0;
    rx_sl <= 1;
    for (k = 0; k < 8; k++) begin
      for (i = 0; i < 64; i++) begin
        @(posedge clk);
        if (rxov && rxrdy) break;
      end
      lim(i);
      chk(rxo, {k[0], 3'h0, k[0] ? 8'hFF : 8'h10, 24'h203040 + k[7:0]});
    end
    #1;
    chk(rxov, 1'b0);
    @(posedge clk);
  endtask : t_fifo
  task automatic t_eop();
    term(T_BAD, K_COL);
    term(T_BAD, K_COL);
    term(T_BAD, K_COL);
    rd(16'h8010, 32'h0000FFFF, 2'h0);
    rd(16'h8010, 32'h00000000, 2'h0);
    term(T_BAD, K_COL);
    term(T_OK, A_COL);
    rd(16'h8010, 32'h00000001, 2'h0);
    term(T_OK, D_COL);
    term(T_BAD, D_COL);
    rd(16'h8010, 32'h00000002, 2'h0);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(16'h8006, 32'h00000000, 2'h0);
  endtask : t_eop
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset_values();
    t_codes();
    t_fifo();
    t_eop();
    print_verdict();
  end
endmodule : kec_top_tb
